/* inc/hpmc_meas_if.sv */
/*
 Carrier between the mode controller and its measurement engine.
 Assumes both ends sit on clk_sys.
*/
`timescale 1ns/1ps
interface hpmc_meas_if #(parameter int W = 8);
	logic         start;
	logic         kind;
	logic         clr;
	logic [W-1:0] sample;
	logic         busy;
	logic         done;
	logic [W-1:0] batt;
	logic [W-1:0] coil;

	modport ctl (output start, kind, clr, sample,
		input busy, done, batt, coil);
	modport eng (input start, kind, clr, sample,
		output busy, done, batt, coil);
endinterface

/* inc/hpmc_pkg.sv */
/*
 Shared constants and types of the haptic power-mode control block.
 Assumes a 200 MHz system clock and an 8-bit measurement converter.
*/
package hpmc_pkg;

	// Power modes, one-hot
	typedef enum logic [2:0] {
		HPMC_PWR_DOWN = 3'h1,
		HPMC_STANDBY  = 3'h2,
		HPMC_ACTIVE   = 3'h4
	} hpmc_mode_t;

	// Measurement engine states, one-hot
	typedef enum logic [1:0] {
		HPMC_M_IDLE = 2'h1,
		HPMC_M_RUN  = 2'h2
	} hpmc_meas_st_t;

	// Measurement kinds
	localparam logic HPMC_MEAS_BATT = 1'b0;
	localparam logic HPMC_MEAS_COIL = 1'b1;

	// Actuator types
	localparam logic HPMC_ACT_LRA = 1'b0;
	localparam logic HPMC_ACT_ERM = 1'b1;

	// Command code that resets the device when written to the id register
	localparam logic [7:0] HPMC_SOFT_RST_CODE = 8'hAA;

	// Values after reset
	localparam logic       HPMC_ACT_TYPE_RST = HPMC_ACT_LRA;
	localparam logic       HPMC_STANDBY_RST  = 1'b1;
	localparam logic       HPMC_GO_RST       = 1'b0;
	localparam logic       HPMC_POE_RST      = 1'b1;
	localparam logic [7:0] HPMC_RESULT_RST   = 8'h00;
	localparam logic [7:0] HPMC_DRIVE_RST    = 8'h00;

	// Field position of the power-on event flag in the status byte
	localparam int HPMC_STAT_POE_BIT = 0;

	// Supply code at which the drive passes unscaled
	localparam logic [7:0] HPMC_DRIVE_REF_LVL = 8'h80;

	// Timing: least settling time of one measurement
	localparam int HPMC_CLK_PERIOD_PS = 5000;
	localparam int HPMC_MEAS_TIME_NS  = 10000;
	localparam int HPMC_MEAS_CYCLES   =
		(HPMC_MEAS_TIME_NS * 1000 + HPMC_CLK_PERIOD_PS - 1)
		/ HPMC_CLK_PERIOD_PS;

endpackage

/* src/hpmc_measure.sv */
/*
 Measurement engine: battery voltage and coil resistance results.
 Assumes the converter sample is valid after the settling time.
*/
`timescale 1ns/1ps
module hpmc_measure
	import hpmc_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	hpmc_meas_if.eng  mif
);

	localparam int CW = $clog2(HPMC_MEAS_CYCLES + 1);

	hpmc_meas_st_t  st_r, st_nxt;
	logic [CW-1:0]  cnt_r, cnt_nxt;
	logic           kind_r, kind_nxt;
	logic           done_r, done_nxt;
	logic [7:0]     batt_r, batt_nxt;
	logic [7:0]     coil_r, coil_nxt;

	////////////////////////////////////////////////////////////////////////
	// Next state: wait the settling time, then latch the sample
	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = cnt_r;
		kind_nxt = kind_r;
		done_nxt = 1'b0;
		batt_nxt = batt_r;
		coil_nxt = coil_r;
		if (mif.clr) begin
			st_nxt   = HPMC_M_IDLE;
			cnt_nxt  = '0;
			kind_nxt = HPMC_MEAS_BATT;
			batt_nxt = HPMC_RESULT_RST; // R21
			coil_nxt = HPMC_RESULT_RST; // R21
		end else begin
			case (st_r)
				HPMC_M_IDLE: begin
					if (mif.start) begin
						st_nxt   = HPMC_M_RUN;
						kind_nxt = mif.kind;
						cnt_nxt  = CW'(HPMC_MEAS_CYCLES - 1);
					end
				end
				HPMC_M_RUN: begin
					if (cnt_r == '0) begin
						st_nxt   = HPMC_M_IDLE;
						done_nxt = 1'b1;
						if (kind_r == HPMC_MEAS_BATT) begin
							batt_nxt = mif.sample; // R14
						end else begin
							coil_nxt = mif.sample; // R15
						end
					end else begin
						cnt_nxt = cnt_r - 1'b1;
					end
				end
				default: begin
					st_nxt = HPMC_M_IDLE;
				end
			endcase
		end
	end

	// Registers
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_r   <= HPMC_M_IDLE;
			cnt_r  <= '0;
			kind_r <= HPMC_MEAS_BATT;
			done_r <= 1'b0;
			batt_r <= HPMC_RESULT_RST;
			coil_r <= HPMC_RESULT_RST;
		end else begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			kind_r <= kind_nxt;
			done_r <= done_nxt;
			batt_r <= batt_nxt;
			coil_r <= coil_nxt;
		end
	end

	assign mif.busy = (st_r == HPMC_M_RUN);
	assign mif.done = done_r;
	assign mif.batt = batt_r;
	assign mif.coil = coil_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_hold;
		@(posedge clk_sys) disable iff (sys_rst)
		!mif.clr && !done_nxt |=> $stable(batt_r) && $stable(coil_r);
	endproperty
	a_hold: assert property (p_hold) // R21
		else $error("result changed without a measurement");

	// Helper for the timing checks: edges spent in the run state
	logic [CW-1:0]  age_r, age_nxt;

	always_comb begin
		age_nxt = age_r;
		if (mif.clr || st_r == HPMC_M_IDLE) begin
			age_nxt = '0;
		end else begin
			age_nxt = age_r + 1'b1;
		end
	end

	// Helper register, no reach into the engine itself
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			age_r <= '0;
		end else begin
			age_r <= age_nxt;
		end
	end

	property p_meas_time;
		@(posedge clk_sys) disable iff (sys_rst)
		done_r |-> age_r == CW'(HPMC_MEAS_CYCLES);
	endproperty
	a_meas_time: assert property (p_meas_time) // R14
		else $error("measurement did not finish on time");

	property p_meas_bound;
		@(posedge clk_sys) disable iff (sys_rst)
		st_r == HPMC_M_RUN |-> age_r < CW'(HPMC_MEAS_CYCLES);
	endproperty
	a_meas_bound: assert property (p_meas_bound) // R15
		else $error("measurement ran past its settling time");

	c_meas: cover property (@(posedge clk_sys) disable iff (sys_rst)
		done_r && kind_r == HPMC_MEAS_COIL);

endmodule

/* src/hpmc_top.sv */
/*
 Power-mode and reset control of a haptic actuator driver: power-on
 reset, power-down/standby/active modes, software reset, power-on event
 flag, actuator type, drive scaling and measurement commands.
 Assumes all strobes are one-cycle pulses synchronous to clk_sys.
*/
// What this block does
// R01: Drive resonant actuator by default; rotating mass only after type write.
// R02: Hold internal reset clearing everything while core supply is not good.
// R03: Set the power-on event flag whenever a power-on reset occurs.
// R04: Reading the status register clears the power-on event flag.
// R05: Enter power-down when supply not ready or shutdown pin low.
// R06: Power-down: circuits off, port silent, configuration cleared.
// R07: Leave power-down unaided once supplies good and shutdown pin high.
// R08: Standby when supply ready, pin high, standby bit one.
// R09: Accept waveform library writes while in standby.
// R10: Return to standby after playback finishes.
// R11: Writing standby bit zero enters active and enables the H-bridge.
// R12: Host configures in standby, then starts playback in active.
// R13: Writing the soft reset code to the id register resets everything; the code leaves the power-on event flag unchanged.
// R14: Battery voltage measured on command, reported as eight bits.
// R15: Coil resistance measured on command, reported as eight bits.
// R16: Host judges short or open coil from result thresholds.
// R17: Scale drive by supply feedback for constant strength.
// R18: Resonant frequency detection runs only on software command.
// R19: Playback end clears go and returns to standby unaided; a go write of one in the same cycle keeps go set.
// R20: Writing standby bit one while active stops driver, keeps registers.
// R21: Measurement results hold until next measurement or reset.
`timescale 1ns/1ps
module hpmc_top
	import hpmc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       core_supply_good,
	input  wire logic       supply_ready,
	input  wire logic       shutdown_pin_n,
	input  wire logic       standby_wr,
	input  wire logic       standby_wr_data,
	input  wire logic       act_type_wr,
	input  wire logic       act_type_wr_data,
	input  wire logic       go_wr,
	input  wire logic       go_wr_data,
	input  wire logic       rtp_sample_wr,
	input  wire logic       lib_wr,
	input  wire logic       status_rd,
	input  wire logic       device_id_wr,
	input  wire logic [7:0] device_id_wr_data,
	input  wire logic       playback_done,
	input  wire logic       meas_cmd,
	input  wire logic       meas_kind,
	input  wire logic [7:0] meas_sample,
	input  wire logic       f0_cmd,
	input  wire logic       f0_done,
	input  wire logic [7:0] drive_amp,
	input  wire logic [7:0] supply_level,
	output logic [2:0]      power_mode,
	output logic            int_rst,
	output logic            port_ready,
	output logic            hbridge_en,
	output logic            actuator_type_select,
	output logic            go_bit,
	output logic            standby_bit,
	output logic [7:0]      system_interrupt_status,
	output logic            power_on_event_flag,
	output logic            lib_wr_accept,
	output logic            rtp_sample_accept,
	output logic            meas_busy,
	output logic            meas_done,
	output logic [7:0]      battery_voltage_result,
	output logic [7:0]      coil_resistance_result,
	output logic            f0_detect_run,
	output logic [7:0]      drive_out
);

	////////////////////////////////////////////////////////////////////////
	// Drive scaling: amplitude times reference over supply, saturated
	function automatic logic [7:0] hpmc_scale(input logic [7:0] amp,
		input logic [7:0] lvl);
		logic [15:0] prod;
		logic [15:0] quo;
		prod = {8'h00, amp} * {8'h00, HPMC_DRIVE_REF_LVL};
		quo  = 16'hFFFF;
		if (lvl != 8'h00) begin
			quo = prod / {8'h00, lvl};
		end
		return (quo > 16'h00FF) ? 8'hFF : quo[7:0];
	endfunction

	hpmc_meas_if #(.W(8)) mif ();

	hpmc_mode_t  mode_r, mode_nxt;
	logic        stby_r, stby_nxt;
	logic        go_r, go_nxt;
	logic        erm_r, erm_nxt;
	logic        poe_r, poe_nxt;
	logic        f0_r, f0_nxt;
	logic [7:0]  drv_r, drv_nxt;
	logic        pd_cond;
	logic        port_ok;
	logic        soft_hit;
	logic        clr;
	logic        is_act;

	////////////////////////////////////////////////////////////////////////
	// Power-down condition, port gate and internal clear
	assign pd_cond  = !core_supply_good || !supply_ready
		|| !shutdown_pin_n; // R05
	assign port_ok  = (mode_r != HPMC_PWR_DOWN) && !pd_cond; // R06
	assign soft_hit = port_ok && device_id_wr
		&& (device_id_wr_data == HPMC_SOFT_RST_CODE); // R13
	assign clr      = pd_cond || (mode_r == HPMC_PWR_DOWN)
		|| soft_hit; // R02 R06 R13
	assign is_act   = (mode_r == HPMC_ACTIVE);

	////////////////////////////////////////////////////////////////////////
	// Configuration bits: standby, go, actuator type
	always_comb begin
		stby_nxt = stby_r;
		go_nxt   = go_r;
		erm_nxt  = erm_r;
		if (clr) begin
			stby_nxt = HPMC_STANDBY_RST;
			go_nxt   = HPMC_GO_RST;
			erm_nxt  = HPMC_ACT_TYPE_RST; // R01
		end else begin
			if (act_type_wr && port_ok) begin
				erm_nxt = act_type_wr_data; // R01
			end
			if (go_r && playback_done) begin
				stby_nxt = 1'b1; // R19 R10
				go_nxt   = 1'b0; // R19
			end else if (standby_wr && port_ok) begin
				stby_nxt = standby_wr_data; // R11 R20
				if (standby_wr_data) begin
					go_nxt = 1'b0; // R20
				end
			end
			if (go_wr && port_ok && is_act) begin
				if (go_wr_data) begin
					go_nxt = 1'b1; // R12
				end else if (!playback_done) begin
					go_nxt = 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode sequencer
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			HPMC_PWR_DOWN: begin
				if (!pd_cond) begin
					mode_nxt = HPMC_STANDBY; // R07
				end
			end
			HPMC_STANDBY: begin
				if (pd_cond) begin
					mode_nxt = HPMC_PWR_DOWN; // R05
				end else if (!stby_nxt) begin
					mode_nxt = HPMC_ACTIVE; // R11
				end
			end
			HPMC_ACTIVE: begin
				if (pd_cond) begin
					mode_nxt = HPMC_PWR_DOWN; // R05
				end else if (stby_nxt) begin
					mode_nxt = HPMC_STANDBY; // R08 R20
				end
			end
			default: begin
				mode_nxt = HPMC_PWR_DOWN;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Power-on event flag, frequency detect and drive level
	always_comb begin
		poe_nxt = poe_r;
		if (!core_supply_good) begin
			poe_nxt = 1'b1; // R03
		end else if (status_rd && port_ok) begin
			poe_nxt = 1'b0; // R04
		end
		f0_nxt = f0_r;
		if (clr || !is_act) begin
			f0_nxt = 1'b0;
		end else if (f0_cmd && port_ok) begin
			f0_nxt = 1'b1; // R18
		end else if (f0_done) begin
			f0_nxt = 1'b0;
		end
		drv_nxt = HPMC_DRIVE_RST;
		if (!clr && is_act && go_r) begin
			drv_nxt = hpmc_scale(drive_amp, supply_level); // R17
		end
	end

	// Registers
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mode_r <= HPMC_PWR_DOWN;
			stby_r <= HPMC_STANDBY_RST;
			go_r   <= HPMC_GO_RST;
			erm_r  <= HPMC_ACT_TYPE_RST;
			poe_r  <= HPMC_POE_RST;
			f0_r   <= 1'b0;
			drv_r  <= HPMC_DRIVE_RST;
		end else begin
			mode_r <= mode_nxt;
			stby_r <= stby_nxt;
			go_r   <= go_nxt;
			erm_r  <= erm_nxt;
			poe_r  <= poe_nxt;
			f0_r   <= f0_nxt;
			drv_r  <= drv_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Measurement engine
	assign mif.start  = meas_cmd && port_ok && !mif.busy; // R14 R15
	assign mif.kind   = meas_kind;
	assign mif.clr    = clr; // R21
	assign mif.sample = meas_sample;

	hpmc_measure u_meas (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.mif     (mif)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign power_mode           = mode_r;
	assign int_rst              = clr;
	assign port_ready           = port_ok;
	assign hbridge_en           = is_act; // R11
	assign actuator_type_select = erm_r;
	assign go_bit               = go_r;
	assign standby_bit          = stby_r;
	assign power_on_event_flag  = poe_r;
	assign lib_wr_accept        = lib_wr && port_ok
		&& (mode_r == HPMC_STANDBY); // R09
	assign rtp_sample_accept    = rtp_sample_wr && port_ok && is_act; // R12
	assign meas_busy            = mif.busy;
	assign meas_done            = mif.done;
	assign battery_voltage_result = mif.batt;
	assign coil_resistance_result = mif.coil;
	assign f0_detect_run        = f0_r;
	assign drive_out            = drv_r;

	// Status byte, flag in its field, other bits zero
	always_comb begin
		system_interrupt_status = 8'h00;
		system_interrupt_status[HPMC_STAT_POE_BIT] = poe_r;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_type;
		port_ok && act_type_wr && !soft_hit
		|=> actuator_type_select == $past(act_type_wr_data);
	endproperty
	a_type: assert property (p_type) // R01
		else $error("actuator type not taken");

	property p_por;
		!core_supply_good |=> standby_bit && !go_bit
			&& !actuator_type_select && power_on_event_flag;
	endproperty
	a_por: assert property (p_por) // R02
		else $error("power-on reset did not clear state");

	property p_poe_clr;
		status_rd && port_ok |=> !power_on_event_flag;
	endproperty
	a_poe_clr: assert property (p_poe_clr) // R04
		else $error("status read left the flag set");

	property p_pd_enter;
		pd_cond |=> power_mode == HPMC_PWR_DOWN;
	endproperty
	a_pd_enter: assert property (p_pd_enter) // R05
		else $error("no power-down on bad supply or pin");

	property p_pd_quiet;
		power_mode == HPMC_PWR_DOWN |-> !port_ready && !hbridge_en
			&& !lib_wr_accept && drive_out == 8'h00;
	endproperty
	a_pd_quiet: assert property (p_pd_quiet) // R06
		else $error("activity in power-down");

	property p_pd_exit;
		power_mode == HPMC_PWR_DOWN && !pd_cond
		##1 !pd_cond |-> power_mode == HPMC_STANDBY;
	endproperty
	a_pd_exit: assert property (p_pd_exit) // R07
		else $error("power-down not left");

	property p_activate;
		power_mode == HPMC_STANDBY && port_ok && standby_wr
		&& !standby_wr_data && !soft_hit |=> hbridge_en;
	endproperty
	a_activate: assert property (p_activate) // R11
		else $error("standby clear did not activate");

	property p_soft;
		soft_hit |=> standby_bit && !go_bit && !actuator_type_select
			&& battery_voltage_result == 8'h00;
	endproperty
	a_soft: assert property (p_soft) // R13
		else $error("soft reset did not clear state");

	property p_done;
		go_bit && playback_done && !clr
		&& !(go_wr && go_wr_data && port_ok)
		|=> !go_bit && power_mode == HPMC_STANDBY;
	endproperty
	a_done: assert property (p_done) // R19
		else $error("playback end did not return to standby");

	property p_f0;
		!f0_detect_run && !(f0_cmd && port_ok) |=> !f0_detect_run;
	endproperty
	a_f0: assert property (p_f0) // R18
		else $error("frequency detect ran uncommanded");

	c_active: cover property (power_mode == HPMC_STANDBY
		##1 power_mode == HPMC_ACTIVE);
	c_done: cover property (go_bit && playback_done);
	c_soft: cover property (soft_hit);

endmodule

/* verification/hpmc_host_model.sv */
/*
 Host model: issues the register strobes of the mode controller.
 Assumes strobes are driven at the falling edge of clk_sys.
*/
`timescale 1ns/1ps
module hpmc_host_model (
	input  wire logic clk_sys,
	input  wire logic accept,
	output logic      standby_wr,
	output logic      standby_wr_data,
	output logic      act_type_wr,
	output logic      act_type_wr_data,
	output logic      go_wr,
	output logic      go_wr_data,
	output logic      rtp_sample_wr,
	output logic      lib_wr,
	output logic      status_rd,
	output logic      device_id_wr,
	output logic [7:0] device_id_wr_data,
	output logic      meas_cmd,
	output logic      meas_kind
);
	// All strobes idle at time zero
	initial begin
		{standby_wr, standby_wr_data, act_type_wr, act_type_wr_data} = 4'h0;
		{go_wr, go_wr_data, rtp_sample_wr, lib_wr, status_rd} = 5'h00;
		{device_id_wr, meas_cmd, meas_kind} = 3'h0;
		device_id_wr_data = 8'h00;
	end

	// One-cycle strobe: 0 standby 1 type 2 go 3 sample 4 lib 5 read 6 id 7 meas
	// The caller sequences setup in standby, then go in active
	task automatic send(input int op, input logic [7:0] d, output logic acc);
		@(negedge clk_sys);
		case (op)
			0: {standby_wr, standby_wr_data} = {1'b1, d[0]};
			1: {act_type_wr, act_type_wr_data} = {1'b1, d[0]};
			2: {go_wr, go_wr_data} = {1'b1, d[0]};
			3: rtp_sample_wr = 1'b1;
			4: lib_wr = 1'b1;
			5: status_rd = 1'b1;
			6: {device_id_wr, device_id_wr_data} = {1'b1, d};
			default: {meas_cmd, meas_kind} = {1'b1, d[0]};
		endcase
		#1 acc = accept;
		@(negedge clk_sys);
		{standby_wr, act_type_wr, go_wr, rtp_sample_wr, lib_wr} = 5'h00;
		{status_rd, device_id_wr, meas_cmd} = 3'h0;
	endtask
endmodule

/* verification/test_haptic_power_mode_control.sv */
/*
 Self-checking bench of the power-mode control block.
 Assumes the host model above drives all register strobes.
*/
`timescale 1ns/1ps
module test_haptic_power_mode_control;
	import hpmc_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic core_supply_good, supply_ready, shutdown_pin_n, playback_done;
	logic f0_cmd, f0_done, acc;
	logic [7:0] meas_sample, drive_amp, supply_level;
	logic standby_wr, standby_wr_data, act_type_wr, act_type_wr_data;
	logic go_wr, go_wr_data, rtp_sample_wr, lib_wr, status_rd;
	logic device_id_wr, meas_cmd, meas_kind;
	logic [7:0] device_id_wr_data;
	logic [2:0] power_mode;
	logic int_rst, port_ready, hbridge_en, actuator_type_select, go_bit;
	logic standby_bit, power_on_event_flag, lib_wr_accept;
	logic rtp_sample_accept, meas_busy, meas_done, f0_detect_run;
	logic [7:0] system_interrupt_status, battery_voltage_result;
	logic [7:0] coil_resistance_result, drive_out;
	int err_count = 0;
	int check_count = 0;
	// Host threshold for an open coil, value arbitrary
	localparam logic [7:0] COIL_HI = 8'hA0;

	// 200 MHz clock
	always #2.5 clk_sys = ~clk_sys;

	hpmc_host_model hpmc_host_model_inst (.clk_sys,
		.accept(lib_wr_accept | rtp_sample_accept), .standby_wr,
		.standby_wr_data, .act_type_wr, .act_type_wr_data, .go_wr,
		.go_wr_data, .rtp_sample_wr, .lib_wr, .status_rd, .device_id_wr,
		.device_id_wr_data, .meas_cmd, .meas_kind);

	hpmc_top hpmc_top_inst (.clk_sys, .sys_rst, .core_supply_good,
		.supply_ready, .shutdown_pin_n, .standby_wr, .standby_wr_data,
		.act_type_wr, .act_type_wr_data, .go_wr, .go_wr_data,
		.rtp_sample_wr, .lib_wr, .status_rd, .device_id_wr,
		.device_id_wr_data, .playback_done, .meas_cmd, .meas_kind,
		.meas_sample, .f0_cmd, .f0_done, .drive_amp, .supply_level,
		.power_mode, .int_rst, .port_ready, .hbridge_en,
		.actuator_type_select, .go_bit, .standby_bit,
		.system_interrupt_status, .power_on_event_flag, .lib_wr_accept,
		.rtp_sample_accept, .meas_busy, .meas_done, .battery_voltage_result,
		.coil_resistance_result, .f0_detect_run, .drive_out);

	////////////////////////////////////////////////////////////////////////
	// Compare and verdict
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One-cycle pulse on a bench-driven line, picked by index
	task automatic pulse(input int which);
		@(negedge clk_sys);
		{f0_cmd, f0_done, playback_done} = 3'h4 >> which;
		@(negedge clk_sys);
		{f0_cmd, f0_done, playback_done} = 3'h0;
	endtask

	task automatic settle;
		repeat (3) @(negedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_power_up;
		chk(power_mode, HPMC_PWR_DOWN);
		chk(port_ready, 8'h00);
		{core_supply_good, supply_ready, shutdown_pin_n} = 3'h7;
		settle();
		chk(power_mode, HPMC_STANDBY);
		chk(power_on_event_flag, 8'h01);
		chk(system_interrupt_status, 8'h01);
		chk(actuator_type_select, HPMC_ACT_LRA);
		chk(hbridge_en, 8'h00);
		hpmc_host_model_inst.send(5, 8'h00, acc);
		chk(power_on_event_flag, 8'h00);
		chk(system_interrupt_status, 8'h00);
	endtask

	task automatic t_active;
		hpmc_host_model_inst.send(4, 8'h00, acc);
		chk(acc, 8'h01);
		hpmc_host_model_inst.send(2, 8'h01, acc);
		chk(go_bit, 8'h00);
		hpmc_host_model_inst.send(0, 8'h00, acc);
		chk(power_mode, HPMC_ACTIVE);
		chk(hbridge_en, 8'h01);
		hpmc_host_model_inst.send(4, 8'h00, acc);
		chk(acc, 8'h00);
		hpmc_host_model_inst.send(3, 8'h00, acc);
		chk(acc, 8'h01);
		hpmc_host_model_inst.send(2, 8'h01, acc);
		@(negedge clk_sys);
		chk(go_bit, 8'h01);
		chk(drive_out, 8'h80);
		supply_level = 8'h20;
		settle();
		chk(drive_out, 8'hFF);
		supply_level = 8'h80;
		settle();
		chk(drive_out, 8'h40);
		pulse(2);
		chk(go_bit, 8'h00);
		chk(power_mode, HPMC_STANDBY);
		settle();
		chk(drive_out, 8'h00);
		hpmc_host_model_inst.send(1, 8'h01, acc);
		chk(actuator_type_select, HPMC_ACT_ERM);
		hpmc_host_model_inst.send(0, 8'h00, acc);
		hpmc_host_model_inst.send(0, 8'h01, acc);
		chk(power_mode, HPMC_STANDBY);
		chk(hbridge_en, 8'h00);
		chk(actuator_type_select, HPMC_ACT_ERM);
	endtask

	task automatic t_f0;
		pulse(0);
		chk(f0_detect_run, 8'h00);
		hpmc_host_model_inst.send(0, 8'h00, acc);
		pulse(0);
		chk(f0_detect_run, 8'h01);
		pulse(1);
		chk(f0_detect_run, 8'h00);
		hpmc_host_model_inst.send(0, 8'h01, acc);
	endtask

	task automatic t_meas(input logic k, input logic [7:0] s,
		input logic [7:0] eb, input logic [7:0] ec);
		int n;
		n = 0;
		meas_sample = s;
		hpmc_host_model_inst.send(7, {7'h00, k}, acc);
		chk(meas_busy, 8'h01);
		while (meas_done !== 1'b1 && n < 2100) begin
			@(negedge clk_sys);
			n++;
		end
		chk(8'(n == HPMC_MEAS_CYCLES), 8'h01);
		chk(meas_done, 8'h01);
		chk(meas_busy, 8'h00);
		chk(battery_voltage_result, eb);
		chk(coil_resistance_result, ec);
		if (k == HPMC_MEAS_COIL) begin
			chk(8'(coil_resistance_result > COIL_HI), 8'(s > COIL_HI));
		end
	endtask

	task automatic t_soft_reset;
		hpmc_host_model_inst.send(6, 8'h55, acc);
		chk(actuator_type_select, HPMC_ACT_ERM);
		hpmc_host_model_inst.send(6, 8'hAA, acc);
		chk(actuator_type_select, HPMC_ACT_LRA);
		chk(battery_voltage_result, 8'h00);
		chk(coil_resistance_result, 8'h00);
		chk(standby_bit, 8'h01);
	endtask

	task automatic t_power_down;
		hpmc_host_model_inst.send(1, 8'h01, acc);
		shutdown_pin_n = 1'b0;
		settle();
		chk(power_mode, HPMC_PWR_DOWN);
		chk(port_ready, 8'h00);
		chk(actuator_type_select, HPMC_ACT_LRA);
		hpmc_host_model_inst.send(1, 8'h01, acc);
		shutdown_pin_n = 1'b1;
		settle();
		chk(power_mode, HPMC_STANDBY);
		chk(actuator_type_select, HPMC_ACT_LRA);
		core_supply_good = 1'b0;
		@(negedge clk_sys);
		chk(int_rst, 8'h01);
		core_supply_good = 1'b1;
		settle();
		chk(power_on_event_flag, 8'h01);
		chk(power_mode, HPMC_STANDBY);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{core_supply_good, supply_ready, shutdown_pin_n} = 3'h0;
		{playback_done, f0_cmd, f0_done} = 3'h0;
		meas_sample = 8'h00;
		drive_amp = 8'h40;
		supply_level = 8'h40;
		repeat (10) @(negedge clk_sys);
		sys_rst = 1'b0;
		@(negedge clk_sys);
		t_power_up();
		t_active();
		t_f0();
		t_meas(HPMC_MEAS_BATT, 8'h5A, 8'h5A, 8'h00);
		t_meas(HPMC_MEAS_COIL, 8'hC3, 8'h5A, 8'hC3);
		t_soft_reset();
		t_power_down();
		complete_run();
	end

	// Watchdog well beyond the expected run
	initial begin
		#100000;
		err_count++;
		complete_run();
	end
endmodule
